/* File: verilog/fmr_pkg.sv */
// Constants shared by both ends of the single-byte firmware memory read.
// Assumes a four-line nibble bus with an active-low frame, one common clock.
package fmr_pkg;

  // ----------------------------------------------------------------------
  // Field codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] START_FW_READ = 4'hD;   // Start code of the read cycle
  localparam logic [3:0] SIZE_ONE_BYTE = 4'h0;   // Only size the target accepts
  localparam logic [3:0] TURN_ONES     = 4'hF;   // Turnaround drive value
  localparam logic [3:0] SYNC_READY    = 4'h0;   // Ready with no wait states
  localparam logic [3:0] BUS_IDLE      = 4'hF;   // Level of an undriven bus

  // ----------------------------------------------------------------------
  // Field geometry and cycle numbers
  // ----------------------------------------------------------------------
  localparam int ADDR_NIBBLES  = 7;              // Nibbles of the memory address
  localparam int ADDR_W        = 28;             // Full memory address width
  localparam int ARRAY_ADDR_W  = 19;             // Byte index inside the array
  localparam int CLK_SIZE      = 10;             // Size field clock
  localparam int CLK_HOST_TAR0 = 11;             // Host drives ones then floats
  localparam int CLK_SYNC      = 13;             // Ready sync clock
  localparam int CLK_DATA_LO   = 14;             // Low data nibble clock
  localparam int CLK_DATA_HI   = 15;             // High data nibble clock
  localparam int CLK_DEV_TAR0  = 16;             // Device drives ones then floats
  localparam int CLK_LAST      = 17;             // Host owns the bus again

  // ----------------------------------------------------------------------
  // Cycle counter width for the host
  // ----------------------------------------------------------------------
  localparam int CNT_W = 5;

endpackage

/* File: verilog/fmr_if.sv */
// Bus carrier joining the host end and the target end of the read cycle.
// Assumes both ends run on one clock; an undriven bus reads as all ones.
`timescale 1ns/1ps
interface fmr_if;

  // Frame from the host, active low
  logic       frame_n;
  // Host drive of the nibble lines
  logic [3:0] host_lad_o;
  logic       host_lad_oe;
  // Target drive of the nibble lines
  logic [3:0] dev_lad_o;
  logic       dev_lad_oe;
  // Resolved level on the nibble lines
  logic [3:0] lad;

  // Resolve the shared lines; the pull-ups give all ones when nobody drives
  assign lad = host_lad_oe ? host_lad_o :
               dev_lad_oe  ? dev_lad_o  : fmr_pkg::BUS_IDLE;

  modport host (
    output frame_n,
    output host_lad_o,
    output host_lad_oe,
    input  lad
  );

  modport dev (
    input  frame_n,
    output dev_lad_o,
    output dev_lad_oe,
    input  lad
  );

endinterface

/* File: verilog/fmr_dev.sv */
// Target end of the single-byte firmware memory read cycle.
// Assumes the host shares the clock, so the bus needs no synchroniser;
// straps and the init pin are asynchronous and are synchronised here.
// The byte array sits outside: it returns read data within three clocks
// of the read request pulse.
`timescale 1ns/1ps

// Summary of operation
// [RULE1] Start nibble 1101 with frame low begins read
// [RULE2] Last nibble before frame rises is start
// [RULE3] Select nibble must equal the strap inputs
// [RULE4] Host sends seven address nibbles, clocks three-nine
// [RULE5] Address arrives most significant nibble first
// [RULE6] Host sends size nibble zero in clock ten
// [RULE7] Host drives ones then floats in clock eleven
// [RULE8] Target takes the bus in clock twelve
// [RULE9] Target drives ready sync zero in clock thirteen
// [RULE10] Low data nibble clock fourteen, high fifteen
// [RULE11] Target drives ones then releases in sixteen
// [RULE12] Host regains the bus in clock seventeen
// [RULE13] Every nibble valid and sampled on rising edge
// [RULE14] Boot device strapped zero, others count upward
// [RULE15] Either reset low releases lines and deselects
// [RULE16] Standby while frame high and idle
// [RULE17] Mismatch keeps lines released until next frame
// [RULE18] Low nineteen address bits pick the byte
module fmr_dev (
  // Clock and reset
  input  wire logic                              clock,
  input  wire logic                              resetn,
  // Bus side
  fmr_if.dev                                     bus,
  // Board pins
  input  wire logic [3:0]                        chip_select_straps,
  input  wire logic                              init_n,
  // Array side
  output logic                                   rd_req,
  output logic      [fmr_pkg::ARRAY_ADDR_W-1:0]  rd_addr,
  input  wire logic [7:0]                        rd_data,
  // Status
  output logic                                   standby
);

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE,       // Waiting for the frame
    ST_START,      // Frame low, latching the start nibble
    ST_ADDR,       // Collecting address nibbles
    ST_SIZE,       // Size nibble
    ST_TAR0,       // Host drives ones then floats
    ST_TAR1,       // Target takes over, drives ones
    ST_SYNC,       // Ready sync on the bus
    ST_DLO,        // Low data nibble on the bus
    ST_DHI,        // High data nibble on the bus
    ST_SKIP        // Not addressed, lines stay released
  } fmr_dev_state_t;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [3:0] strap_meta_q;
  logic [3:0] strap_q;
  logic       init_meta_q;
  logic       init_q;

  // Two flops on the straps and on the init pin
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      strap_meta_q <= 4'h0;
      strap_q      <= 4'h0;
      init_meta_q  <= 1'b0;
      init_q       <= 1'b0;
    end else begin
      strap_meta_q <= chip_select_straps;
      strap_q      <= strap_meta_q;
      init_meta_q  <= init_n;
      init_q       <= init_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Cycle tracking
  // ----------------------------------------------------------------------
  fmr_dev_state_t                     state_q, state_d;
  logic [3:0]                         start_q, start_d;
  logic [2:0]                         nib_q, nib_d;
  logic [fmr_pkg::ADDR_W-1:0]         addr_q, addr_d;
  logic [7:0]                         data_q, data_d;
  logic [3:0]                         lad_o_q, lad_o_d;
  logic                               lad_oe_q, lad_oe_d;
  logic                               req_q, req_d;
  logic [fmr_pkg::ARRAY_ADDR_W-1:0]   raddr_q, raddr_d;
  logic                               stby_q, stby_d;

  // Next values of the cycle engine
  always_comb begin
    state_d  = state_q;
    start_d  = start_q;
    nib_d    = nib_q;
    addr_d   = addr_q;
    data_d   = data_q;
    lad_o_d  = fmr_pkg::TURN_ONES;
    lad_oe_d = 1'b0;
    req_d    = 1'b0;
    raddr_d  = raddr_q;
    if (!init_q) begin
      // Init pin low: deselect and float the lines
      state_d  = ST_IDLE;                                   // RULE15
      lad_oe_d = 1'b0;                                      // RULE15
    end else if (!bus.frame_n) begin
      // Frame low aborts anything and keeps the latest nibble
      state_d = ST_START;                                   // RULE1
      start_d = bus.lad;                                    // RULE2 RULE13
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_d = ST_IDLE;
        end
        ST_START: begin
          // Frame just rose: bus now holds the select nibble
          nib_d = 3'h0;
          if (start_q == fmr_pkg::START_FW_READ             // RULE1 RULE2
              && bus.lad == strap_q) begin                  // RULE3 RULE14
            state_d = ST_ADDR;
          end else begin
            state_d = ST_SKIP;                              // RULE17
          end
        end
        ST_ADDR: begin
          // Shift in most significant nibble first
          addr_d = {addr_q[fmr_pkg::ADDR_W-5:0], bus.lad};  // RULE4 RULE5
          nib_d  = nib_q + 3'h1;
          if (nib_q == 3'(fmr_pkg::ADDR_NIBBLES - 1)) begin
            state_d = ST_SIZE;
            req_d   = 1'b1;
            raddr_d = {addr_q[fmr_pkg::ARRAY_ADDR_W-5:0], bus.lad}; // RULE18
          end
        end
        ST_SIZE: begin
          // Only single-byte transfers exist
          if (bus.lad == fmr_pkg::SIZE_ONE_BYTE) begin      // RULE6
            state_d = ST_TAR0;
          end else begin
            state_d = ST_SKIP;                              // RULE17
          end
        end
        ST_TAR0: begin
          // Host drives ones now and floats next; take the bus for the next clock
          state_d  = ST_TAR1;                               // RULE7
          lad_oe_d = 1'b1;                                  // RULE8
          lad_o_d  = fmr_pkg::TURN_ONES;                    // RULE8
        end
        ST_TAR1: begin
          // Array data is settled; present ready sync next
          state_d  = ST_SYNC;
          data_d   = rd_data;
          lad_oe_d = 1'b1;
          lad_o_d  = fmr_pkg::SYNC_READY;                   // RULE9
        end
        ST_SYNC: begin
          state_d  = ST_DLO;
          lad_oe_d = 1'b1;
          lad_o_d  = data_q[3:0];                           // RULE10
        end
        ST_DLO: begin
          state_d  = ST_DHI;
          lad_oe_d = 1'b1;
          lad_o_d  = data_q[7:4];                           // RULE10
        end
        ST_DHI: begin
          // Ones for one clock, then released at the next edge
          state_d  = ST_IDLE;                               // RULE12
          lad_oe_d = 1'b1;
          lad_o_d  = fmr_pkg::TURN_ONES;                    // RULE11
        end
        ST_SKIP: begin
          state_d = ST_SKIP;                                // RULE17
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  // Standby while the frame is high and nothing is in progress
  always_comb begin
    stby_d = bus.frame_n && init_q                          // RULE16
             && (state_d == ST_IDLE || state_d == ST_SKIP);
  end

  // Register the cycle engine; reset floats the lines
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q  <= ST_IDLE;
      start_q  <= 4'h0;
      nib_q    <= 3'h0;
      addr_q   <= '0;
      data_q   <= 8'h00;
      lad_o_q  <= fmr_pkg::TURN_ONES;
      lad_oe_q <= 1'b0;                                     // RULE15
      req_q    <= 1'b0;
      raddr_q  <= '0;
      stby_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      start_q  <= start_d;
      nib_q    <= nib_d;
      addr_q   <= addr_d;
      data_q   <= data_d;
      lad_o_q  <= lad_o_d;
      lad_oe_q <= lad_oe_d;
      req_q    <= req_d;
      raddr_q  <= raddr_d;
      stby_q   <= stby_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign bus.dev_lad_o  = lad_o_q;
  assign bus.dev_lad_oe = lad_oe_q;
  assign rd_req         = req_q;
  assign rd_addr        = raddr_q;
  assign standby        = stby_q;

endmodule // fmr_dev

/* File: verilog/fmr_host.sv */
// Host end of the single-byte firmware memory read cycle.
// Assumes the target shares the clock; a user request starts one read.
`timescale 1ns/1ps
module fmr_host (
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        resetn,
  // Bus side
  fmr_if.host                              bus,
  // Request side
  input  wire logic                        req_valid,
  input  wire logic [3:0]                  req_select,
  input  wire logic [fmr_pkg::ADDR_W-1:0]  req_addr,
  output logic                             busy,
  // Answer side
  output logic                             rsp_valid,
  output logic                             rsp_error,
  output logic      [7:0]                  rsp_data
);

  // ----------------------------------------------------------------------
  // Cycle engine
  // ----------------------------------------------------------------------
  logic [fmr_pkg::CNT_W-1:0]   cnt_q, cnt_d;
  logic [fmr_pkg::ADDR_W-1:0]  addr_q, addr_d;
  logic [3:0]                  sel_q, sel_d;
  logic [3:0]                  lad_o_q, lad_o_d;
  logic                        lad_oe_q, lad_oe_d;
  logic                        frame_n_q, frame_n_d;
  logic                        ok_q, ok_d;
  logic [7:0]                  data_q, data_d;
  logic                        vld_q, vld_d;
  logic                        err_q, err_d;
  logic                        busy_q, busy_d;

  // Next values; cnt_q is the clock number now on the bus, zero when idle
  always_comb begin
    cnt_d     = cnt_q;
    addr_d    = addr_q;
    lad_o_d   = lad_o_q;
    lad_oe_d  = lad_oe_q;
    frame_n_d = 1'b1;
    ok_d      = ok_q;
    data_d    = data_q;
    vld_d     = 1'b0;
    err_d     = err_q;
    sel_d     = sel_q;
    if (cnt_q == '0) begin
      if (req_valid) begin
        // Clock one: frame low with the start code; select kept for clock two
        cnt_d     = 5'h1;
        frame_n_d = 1'b0;
        lad_o_d   = fmr_pkg::START_FW_READ;               // RULE1
        lad_oe_d  = 1'b1;
        addr_d    = req_addr;
        sel_d     = req_select;
      end
    end else begin
      cnt_d = cnt_q + 5'h1;
      if (cnt_q == 5'h1) begin
        lad_o_d = sel_q;                                  // RULE3
      end else if (cnt_q < 5'(fmr_pkg::CLK_SIZE - 1)) begin
        // Address nibbles, most significant first
        lad_o_d = addr_q[fmr_pkg::ADDR_W-1 -: 4];         // RULE4 RULE5
        addr_d  = {addr_q[fmr_pkg::ADDR_W-5:0], 4'h0};
      end
      if (cnt_q == 5'(fmr_pkg::CLK_SIZE - 1)) begin
        lad_o_d = fmr_pkg::SIZE_ONE_BYTE;                 // RULE6
      end else if (cnt_q == 5'(fmr_pkg::CLK_SIZE)) begin
        lad_o_d = fmr_pkg::TURN_ONES;                     // RULE7
      end else if (cnt_q == 5'(fmr_pkg::CLK_HOST_TAR0)) begin
        lad_oe_d = 1'b0;                                  // RULE7
      end else if (cnt_q == 5'(fmr_pkg::CLK_SYNC)) begin
        ok_d = (bus.lad == fmr_pkg::SYNC_READY);          // RULE9 RULE13
      end else if (cnt_q == 5'(fmr_pkg::CLK_DATA_LO)) begin
        data_d[3:0] = bus.lad;                            // RULE10
      end else if (cnt_q == 5'(fmr_pkg::CLK_DATA_HI)) begin
        data_d[7:4] = bus.lad;                            // RULE10
      end else if (cnt_q == 5'(fmr_pkg::CLK_DEV_TAR0)) begin
        lad_oe_d = 1'b1;                                  // RULE12
        lad_o_d  = fmr_pkg::TURN_ONES;
      end else if (cnt_q == 5'(fmr_pkg::CLK_LAST)) begin
        cnt_d = '0;
        vld_d = 1'b1;
        err_d = !ok_q;
      end
    end
    // Busy while a cycle is on the bus, registered so the pin comes from a flop
    busy_d = (cnt_d != '0);
  end

  // Register the engine; the host idles driving ones
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_q     <= '0;
      addr_q    <= '0;
      lad_o_q   <= fmr_pkg::TURN_ONES;
      lad_oe_q  <= 1'b1;
      frame_n_q <= 1'b1;
      ok_q      <= 1'b0;
      data_q    <= 8'h00;
      vld_q     <= 1'b0;
      err_q     <= 1'b0;
      sel_q     <= 4'h0;
      busy_q    <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      addr_q    <= addr_d;
      lad_o_q   <= lad_o_d;
      lad_oe_q  <= lad_oe_d;
      frame_n_q <= frame_n_d;
      ok_q      <= ok_d;
      data_q    <= data_d;
      vld_q     <= vld_d;
      err_q     <= err_d;
      sel_q     <= sel_d;
      busy_q    <= busy_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign bus.frame_n     = frame_n_q;
  assign bus.host_lad_o  = lad_o_q;
  assign bus.host_lad_oe = lad_oe_q;
  assign busy            = busy_q;
  assign rsp_valid       = vld_q;
  assign rsp_error       = err_q;
  assign rsp_data        = data_q;

endmodule // fmr_host

/* File: tb/fmr_properties.sv */
// Concurrent checks on the nibble bus joining the host end and the target end.
// Assumes one clock; takes the carrier's signals as plain inputs.
`timescale 1ns/1ps
module fmr_properties (
  // Clock and reset
  input wire logic       clock,
  input wire logic       resetn,
  // Carrier signals
  input wire logic       frame_n,
  input wire logic [3:0] host_lad_o,
  input wire logic       host_lad_oe,
  input wire logic [3:0] dev_lad_o,
  input wire logic       dev_lad_oe,
  input wire logic [3:0] lad
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // --------------------------------------------------------------------
  // Steps of a granted read
  // --------------------------------------------------------------------
  // Target takes the lines at clock twelve
  sequence s_take;
    $rose(dev_lad_oe) ##0 !host_lad_oe;
  endsequence
  // Sync, two data clocks, ones, then host owns the lines again
  sequence s_answer;
    lad == fmr_pkg::SYNC_READY ##1 dev_lad_oe [*2] ##1 lad == fmr_pkg::TURN_ONES
      ##1 (!dev_lad_oe && host_lad_oe);
  endsequence

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  a_no_overlap: assert property (!(host_lad_oe && dev_lad_oe))
    else $error("both ends drive the lines");
  a_frame_pulse: assert property ($fell(frame_n) |=> frame_n)
    else $error("frame low longer than one clock");
  a_start_code: assert property (!frame_n |-> lad == fmr_pkg::START_FW_READ)
    else $error("wrong start nibble with frame low");
  a_host_release: assert property (s_take |-> $past(host_lad_oe)
    && $past(host_lad_o) == fmr_pkg::TURN_ONES) else $error("host did not drive ones");
  a_dev_turn: assert property (s_take |-> dev_lad_o == fmr_pkg::TURN_ONES)
    else $error("target turnaround not all ones");
  a_turn_timing: assert property (s_take |-> !$past(frame_n, 11) && $past(frame_n, 10))
    else $error("target took lines at wrong clock");
  a_size_zero: assert property (s_take |-> $past(lad, 2) == fmr_pkg::SIZE_ONE_BYTE)
    else $error("target answered a bad size");
  a_ready_sync: assert property (s_take |=> lad == fmr_pkg::SYNC_READY)
    else $error("no ready sync at clock thirteen");
  a_data_owned: assert property (s_take |-> dev_lad_oe [*5])
    else $error("target dropped lines early");
  a_hand_back: assert property (s_take |=> s_answer)
    else $error("hand-back sequence broken");

endmodule // fmr_properties

/* File: tb/tb.sv */
// Self-checking bench: host and target joined on one carrier, and a second
// target driven directly by the bench to break the host's side on purpose.
// Assumes the design package, carrier and both ends are compiled first.
`timescale 1ns/1ps
module tb;
  // --------------------------------------------------------------------
  // Signals and case tables
  // --------------------------------------------------------------------
  logic        clock, resetn, req_valid, busy, rsp_valid, rsp_error, init_x;
  logic        rd_req_a, standby_x;
  logic [3:0]  req_select, strap_a, strap_x;
  logic [27:0] req_addr;
  logic [7:0]  rsp_data;
  logic [18:0] rd_addr_a, rd_addr_x, seen_addr;
  logic [3:0]  trace [18];
  int          mismatches, n_compared;
  int          cyc = 0;
  localparam logic [27:0] X_ADDR = 28'h7654321;
  // Host rows: select, straps, address, expected error
  logic [3:0]  r_sel [5]   = '{4'h0, 4'h0, 4'h5, 4'hF, 4'h3};
  logic [3:0]  r_strap [5] = '{4'h0, 4'h0, 4'h5, 4'hF, 4'h4};
  logic [27:0] r_addr [5]  = '{28'h0, 28'hFFFFFFF, 28'h1234567, 28'hABCDEF0, 28'h1234};
  logic        r_err [5]   = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  // Direct rows: first nibble, start, select, size, init pulse, answered
  logic [3:0]  x_first [5] = '{4'hE, 4'hD, 4'hD, 4'hD, 4'hD};
  logic [3:0]  x_start [5] = '{4'hD, 4'hE, 4'hD, 4'hD, 4'hD};
  logic [3:0]  x_sel [5]   = '{4'h3, 4'h3, 4'h4, 4'h3, 4'h3};
  logic [3:0]  x_size [5]  = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h0};
  logic        x_init [5]  = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic        x_ans [5]   = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

  // Array contents as a fixed function of the byte index
  function automatic logic [7:0] mem_byte(input logic [18:0] a);
    return a[7:0] ^ a[18:11] ^ 8'h5A;
  endfunction

  // --------------------------------------------------------------------
  // Design instances and checker
  // --------------------------------------------------------------------
  fmr_if bus_a ();
  fmr_if bus_x ();
  fmr_host fmr_host_i (.clock(clock), .resetn(resetn), .bus(bus_a), .req_valid(req_valid),
    .req_select(req_select), .req_addr(req_addr), .busy(busy), .rsp_valid(rsp_valid),
    .rsp_error(rsp_error), .rsp_data(rsp_data));
  fmr_dev fmr_dev_i (.clock(clock), .resetn(resetn), .bus(bus_a), .chip_select_straps(strap_a),
    .init_n(1'b1), .rd_req(rd_req_a), .rd_addr(rd_addr_a), .rd_data(mem_byte(rd_addr_a)),
    .standby());
  fmr_dev fmr_dev_x_i (.clock(clock), .resetn(resetn), .bus(bus_x), .chip_select_straps(strap_x),
    .init_n(init_x), .rd_req(), .rd_addr(rd_addr_x), .rd_data(mem_byte(rd_addr_x)),
    .standby(standby_x));
  fmr_properties fmr_properties_i (.clock(clock), .resetn(resetn), .frame_n(bus_a.frame_n),
    .host_lad_o(bus_a.host_lad_o), .host_lad_oe(bus_a.host_lad_oe), .dev_lad_o(bus_a.dev_lad_o),
    .dev_lad_oe(bus_a.dev_lad_oe), .lad(bus_a.lad));

  // Clock of 10 ns
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Record the lines of the joined pair by clock number of the cycle
  always @(posedge clock) begin
    if (rd_req_a === 1'b1) seen_addr <= rd_addr_a;
    if (!bus_a.frame_n) begin
      trace[1] <= bus_a.lad;
      cyc      <= 2;
    end else if (cyc != 0) begin
      trace[cyc] <= bus_a.lad;
      cyc        <= (cyc == 17) ? 0 : cyc + 1;
    end
  end

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Compared %0d, mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // One host read, called at a rising edge; returns once the answer shows
  task automatic do_read(input logic [3:0] sel, input logic [27:0] addr);
    int k;
    req_valid  <= 1'b1;
    req_select <= sel;
    req_addr   <= addr;
    @(posedge clock);
    req_valid <= 1'b0;
    #1;
    check(busy, 1'b1, "busy after take");
    k = 0;
    while (rsp_valid !== 1'b1 && k < 30) begin
      @(posedge clock);
      #1;
      k++;
    end
    if (k >= 30) begin
      mismatches++;
      $display("BAD %0t no answer from host", $time);
      complete_run();
    end
    check(k, fmr_pkg::CLK_LAST, "answer latency");
    check(busy, 1'b0, "idle at answer");
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    logic [7:0] b;
    logic       drove;
    logic [3:0] got [17];
    mismatches = 0;
    n_compared = 0;
    resetn = 1'b0;
    req_valid = 1'b0;
    req_select = 4'h0;
    req_addr = 28'h0;
    strap_a = 4'h0;
    strap_x = 4'h3;
    init_x = 1'b1;
    bus_x.frame_n = 1'b1;
    bus_x.host_lad_oe = 1'b1;
    bus_x.host_lad_o = fmr_pkg::TURN_ONES;
    repeat (3) @(posedge clock);
    #1;
    check(bus_a.dev_lad_oe, 1'b0, "target released in reset");
    check(bus_a.frame_n, 1'b1, "frame idle in reset");
    @(posedge clock);
    resetn <= 1'b1;
    $display("reset test done");
    // Host rows through the joined pair
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      strap_a <= r_strap[i];
      repeat (3) @(posedge clock);
      do_read(r_sel[i], r_addr[i]);
      b = mem_byte(r_addr[i][18:0]);
      check(rsp_error, r_err[i], "error flag");
      check(trace[13], r_err[i] ? 4'hF : fmr_pkg::SYNC_READY, "sync nibble");
      check(trace[2], r_sel[i], "select nibble");
      check(trace[10], fmr_pkg::SIZE_ONE_BYTE, "size nibble");
      for (int n = 0; n < 7; n++) check(trace[3+n], r_addr[i][27-4*n -: 4], "addr");
      if (!r_err[i]) begin
        check(rsp_data, b, "read byte");
        check(seen_addr, r_addr[i][18:0], "array index");
        check({trace[15], trace[14]}, b, "data nibble order");
      end
      $display("host row %0d done", i);
    end
    // Direct rows on the second carrier
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      #1;
      check(standby_x, 1'b1, "standby when idle");
      @(posedge clock);
      bus_x.frame_n    <= 1'b0;
      bus_x.host_lad_o <= x_first[i];
      @(posedge clock);
      bus_x.host_lad_o <= x_start[i];
      @(posedge clock);
      bus_x.frame_n    <= 1'b1;
      bus_x.host_lad_o <= x_sel[i];
      for (int n = 0; n < 7; n++) begin
        @(posedge clock);
        bus_x.host_lad_o <= X_ADDR[27-4*n -: 4];
        if (x_init[i]) init_x <= 1'b0;
      end
      @(posedge clock);
      bus_x.host_lad_o <= x_size[i];
      @(posedge clock);
      bus_x.host_lad_o <= fmr_pkg::TURN_ONES;
      @(posedge clock);
      bus_x.host_lad_oe <= 1'b0;
      drove = 1'b0;
      for (int k = 12; k <= 16; k++) begin
        #1;
        got[k] = bus_x.lad;
        drove |= bus_x.dev_lad_oe;
        if (k == 13 && x_ans[i]) check(standby_x, 1'b0, "busy target");
        @(posedge clock);
      end
      bus_x.host_lad_oe <= 1'b1;
      b = mem_byte(X_ADDR[18:0]);
      check(drove, x_ans[i], "target drive");
      if (x_ans[i]) begin
        check({got[16], got[13], got[12]}, 12'hF0F, "turn and sync");
        check({got[15], got[14]}, b, "direct data");
      end
      init_x <= 1'b1;
      repeat (4) @(posedge clock);
      $display("direct row %0d done", i);
    end
    // Reset while the target owns the lines, then a clean read
    strap_a <= 4'h2;
    repeat (3) @(posedge clock);
    req_valid  <= 1'b1;
    req_select <= 4'h2;
    req_addr   <= 28'h00000AA;
    @(posedge clock);
    req_valid <= 1'b0;
    repeat (13) @(posedge clock);
    #1;
    check(bus_a.dev_lad_oe, 1'b1, "target owns lines");
    @(posedge clock);
    resetn <= 1'b0;
    #1;
    check(bus_a.dev_lad_oe, 1'b0, "released by reset");
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    do_read(4'h2, 28'h00000AA);
    check(rsp_data, mem_byte(19'hAA), "read after reset");
    $display("mid-run reset test done");
    complete_run();
  end

endmodule // tb
